// ---- design/pnsc_pkg.sv ----
// Functional notes
// - Expansion status bits 15 to 5 always read as zero.
// - Expansion bit 4 shows one when a multiple link fault occurred.
// - Expansion bit 3 shows whether the partner supports next pages.
// - Expansion bit 2 shows whether local node can send next pages; not reset, follows its input.
// - Page-received bit 1 sets on new page, clears on partner ability read.
// - Expansion bit 0 shows one when partner supports auto-negotiation.
// - Disconnect counter counts disconnect events and clears when read.
// - Disconnect counter wraps from all ones to zero.
// - False-carrier counter counts events, starts zero, clears on read.
// - Test bit 7 puts negotiation into loopback; resets zero.
// - Test bit 3 makes first LED show link pulses.
// - Test bits 2,1,0 record ability-detect, parallel-fault, link-check states.
// - Receive counter counts valid packets, starts zero, clears on read.
// - Write-only config bit 15 shortens negotiation timers.
// - Config bit 9 is active-low link disable; resets one.
// - Config bit 8 enables heartbeat, resets one, only at 10 Mb/s.
// - Config bit 7 enables jabber detection; resets one.
// - Config bit 6 low forces good 100 Mb/s link; resets one.
// - Config bit 5 bypasses disconnect detection; resets zero.
// - Config bit 3 reads one for connected link, zero otherwise.
// - Config bit 2 makes second LED show connection status.
// - Partner ability register is read-only at index 0068h.
package pnsc_pkg;
  localparam int PNSC_AW = 12;
  localparam int PNSC_RW = 16;
  // printed offsets are register indices; byte address is four times that
  localparam logic [PNSC_AW-1:0] PNSC_IDX_PARTNER = 12'h068;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_EXP = 12'h06A;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_DISC = 12'h06C;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_FCAR = 12'h06E;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_TEST = 12'h070;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_RXPK = 12'h072;
  localparam logic [PNSC_AW-1:0] PNSC_IDX_CFG = 12'h074;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_PARTNER = PNSC_IDX_PARTNER << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_EXP = PNSC_IDX_EXP << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_DISC = PNSC_IDX_DISC << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_FCAR = PNSC_IDX_FCAR << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_TEST = PNSC_IDX_TEST << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_RXPK = PNSC_IDX_RXPK << 2;
  localparam logic [PNSC_AW-1:0] PNSC_ADR_CFG = PNSC_IDX_CFG << 2;
  // expansion field positions
  localparam int PNSC_EXP_MFLT = 4;
  localparam int PNSC_EXP_PNP = 3;
  localparam int PNSC_EXP_LNP = 2;
  localparam int PNSC_EXP_PRX = 1;
  localparam int PNSC_EXP_PAN = 0;
  // test field positions
  localparam int PNSC_TST_LPBK = 7;
  localparam int PNSC_TST_LEDP = 3;
  localparam int PNSC_TST_ABD = 2;
  localparam int PNSC_TST_PDF = 1;
  localparam int PNSC_TST_LSC = 0;
  localparam logic [15:0] PNSC_TST_WMASK = 16'h0088;
  localparam logic [15:0] PNSC_TST_RST = 16'h0000;
  // config field positions
  localparam int PNSC_CFG_TFUN = 15;
  localparam int PNSC_CFG_LDN = 9;
  localparam int PNSC_CFG_HB = 8;
  localparam int PNSC_CFG_JAB = 7;
  localparam int PNSC_CFG_FL100N = 6;
  localparam int PNSC_CFG_FCON = 5;
  localparam int PNSC_CFG_CST = 3;
  localparam int PNSC_CFG_CSTEN = 2;
  localparam int PNSC_CFG_SCR = 0;
  localparam logic [15:0] PNSC_CFG_WMASK = 16'h83E5;
  localparam logic [15:0] PNSC_CFG_RMASK = 16'h03E5;
  localparam logic [15:0] PNSC_CFG_RST = 16'h03C0;
  localparam logic [15:0] PNSC_CNT_RST = 16'h0000;
  localparam logic [1:0] PNSC_RESP_OKAY = 2'b00;
  localparam logic [1:0] PNSC_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PNSC_RD_IDLE = 2'b01,
    PNSC_RD_DATA = 2'b10
  } pnsc_rd_e;
endpackage

// ---- design/pnsc_evcnt.sv ----
`timescale 1ns/1ps
module pnsc_evcnt
#(
  parameter int W = 16
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic event_pulse, // one-cycle count event
  input wire logic read_clear, // software read of this counter
  output logic [W-1:0] count_q // current count
);
  logic [W-1:0] count_d;

  // a read in the same cycle as an event restarts at one so it is not lost
  always_comb
  begin
    count_d = count_q;
    if (read_clear && event_pulse)
      count_d = W'(1);
    else if (read_clear)
      count_d = '0;
    else if (event_pulse)
      count_d = count_q + W'(1); // wraps at all ones
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= '0;
    else
      count_q <= count_d;
  end
endmodule // pnsc_evcnt

// ---- design/pnsc_top.sv ----
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module pnsc_top
  import pnsc_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic aclk, // 200 MHz system clock
  input wire logic aresetn, // sync reset, active low
  // axi4-lite slave
  input wire logic [pnsc_pkg::PNSC_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [pnsc_pkg::PNSC_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  // line-side status and events, same clock
  input wire logic [15:0] partner_ability, // partner ability word
  input wire logic page_received_evt, // new link code word page
  input wire logic multiple_fault_flag, // multiple link fault seen
  input wire logic partner_next_page_capable, // partner next page
  input wire logic local_next_page_capable, // local next page
  input wire logic partner_autoneg_capable, // partner negotiates
  input wire logic disconnect_evt, // disconnect event pulse
  input wire logic false_carrier_evt, // false carrier pulse
  input wire logic rx_packet_evt, // valid packet pulse
  input wire logic ability_detect_evt, // in ability detect state
  input wire logic parallel_fault_evt, // in parallel fault state
  input wire logic link_check_evt, // in link status check state
  input wire logic link_connected, // connected link detected
  input wire logic link_pulse, // link pulse seen
  input wire logic speed_is_10, // link runs at 10 Mb/s
  input wire logic first_led_activity, // normal first led source
  input wire logic second_led_activity, // normal second led source
  // controls toward the line logic
  output logic negotiation_loopback, // loopback mode
  output logic timer_speedup, // shortened timers
  output logic link_disable_n, // link disable, active low
  output logic heartbeat_active, // heartbeat applied
  output logic jabber_enable, // jabber detection on
  output logic force_link_100_n, // force good link, active low
  output logic disconnect_bypass, // skip disconnect detection
  output logic scrambler_bypass, // skip scrambler
  output logic first_led_output, // first led drive
  output logic second_led_output // second led drive
);
  import pnsc_pkg::*;

  function automatic logic [15:0] merge_strb(
    input logic [15:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb,
    input logic [15:0] wmask
  );
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge_strb = (old_v & ~m) | (new_v[15:0] & m);
  endfunction

  function automatic logic addr_known(input logic [PNSC_AW-1:0] a);
    addr_known = (a == PNSC_ADR_PARTNER) || (a == PNSC_ADR_EXP) ||
      (a == PNSC_ADR_DISC) || (a == PNSC_ADR_FCAR) ||
      (a == PNSC_ADR_TEST) || (a == PNSC_ADR_RXPK) ||
      (a == PNSC_ADR_CFG);
  endfunction

  // write channel holding
  logic aw_held_q;
  logic [PNSC_AW-1:0] awaddr_q;
  logic w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // read channel
  pnsc_rd_e rd_state_q;
  pnsc_rd_e rd_state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;

  // register state
  logic [15:0] test_q;
  logic [15:0] test_d;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic page_rx_q;
  logic [2:0] hist_q;
  logic [CW-1:0] disc_cnt;
  logic [CW-1:0] fcar_cnt;
  logic [CW-1:0] rxpk_cnt;

  // output flops
  logic first_led_q;
  logic second_led_q;
  logic hb_q;

  // handshakes
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire wr_ok = addr_known(awaddr_q);

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = (rd_state_q == PNSC_RD_IDLE);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = (rd_state_q == PNSC_RD_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // write decode
  wire wr_test = wr_go && (awaddr_q == PNSC_ADR_TEST);
  wire wr_cfg = wr_go && (awaddr_q == PNSC_ADR_CFG);

  // read decode; clear-on-read acts when the address is taken
  wire rd_partner = ar_fire && (s_axi_araddr == PNSC_ADR_PARTNER);
  wire rd_exp = ar_fire && (s_axi_araddr == PNSC_ADR_EXP);
  wire rd_disc = ar_fire && (s_axi_araddr == PNSC_ADR_DISC);
  wire rd_fcar = ar_fire && (s_axi_araddr == PNSC_ADR_FCAR);
  wire rd_test = ar_fire && (s_axi_araddr == PNSC_ADR_TEST);
  wire rd_rxpk = ar_fire && (s_axi_araddr == PNSC_ADR_RXPK);
  wire rd_cfg = ar_fire && (s_axi_araddr == PNSC_ADR_CFG);

  // expansion word; upper bits stay zero
  wire [15:0] exp_word = {
    11'h000,
    multiple_fault_flag,
    partner_next_page_capable,
    local_next_page_capable,
    page_rx_q,
    partner_autoneg_capable
  };

  wire [15:0] test_word = {
    8'h00,
    test_q[PNSC_TST_LPBK],
    3'b000,
    test_q[PNSC_TST_LEDP],
    hist_q
  };

  // write-only bit 15 and reserved bits read zero; status in bit 3
  wire [15:0] cfg_word = (cfg_q & PNSC_CFG_RMASK) |
    (16'(link_connected) << PNSC_CFG_CST);

  always_comb
  begin
    rdata_d = 32'h00000000;
    if (rd_partner)
      rdata_d = {16'h0000, partner_ability};
    else if (rd_exp)
      rdata_d = {16'h0000, exp_word};
    else if (rd_disc)
      rdata_d = {16'h0000, 16'(disc_cnt)};
    else if (rd_fcar)
      rdata_d = {16'h0000, 16'(fcar_cnt)};
    else if (rd_test)
      rdata_d = {16'h0000, test_word};
    else if (rd_rxpk)
      rdata_d = {16'h0000, 16'(rxpk_cnt)};
    else if (rd_cfg)
      rdata_d = {16'h0000, cfg_word};
  end

  always_comb
  begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      PNSC_RD_IDLE:
      begin
        if (s_axi_arvalid)
          rd_state_d = PNSC_RD_DATA;
      end
      PNSC_RD_DATA:
      begin
        if (s_axi_rready)
          rd_state_d = PNSC_RD_IDLE;
      end
      default:
        rd_state_d = PNSC_RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q <= PNSC_RD_IDLE;
      rdata_q <= 32'h00000000;
      rresp_q <= PNSC_RESP_OKAY;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      if (ar_fire)
      begin
        rdata_q <= rdata_d;
        rresp_q <= addr_known(s_axi_araddr) ? PNSC_RESP_OKAY : PNSC_RESP_SLVERR;
      end
    end
  end

  // address and data may arrive in either order; response follows both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= PNSC_RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? PNSC_RESP_OKAY : PNSC_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // only the writable bits move; read-only and reserved bits are masked
  assign test_d = wr_test ?
    merge_strb(test_q, wdata_q, wstrb_q, PNSC_TST_WMASK) : test_q;
  assign cfg_d = wr_cfg ?
    merge_strb(cfg_q, wdata_q, wstrb_q, PNSC_CFG_WMASK) : cfg_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_q <= PNSC_TST_RST;
      cfg_q <= PNSC_CFG_RST;
    end
    else
    begin
      test_q <= test_d;
      cfg_q <= cfg_d;
    end
  end

  // a new page in the cycle of the partner read keeps the flag set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      page_rx_q <= 1'b0;
    else if (page_received_evt)
      page_rx_q <= 1'b1;
    else if (rd_partner)
      page_rx_q <= 1'b0;
  end

  // history flags are sticky until reset; nothing in software clears them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hist_q <= 3'b000;
    else
    begin
      if (ability_detect_evt)
        hist_q[PNSC_TST_ABD] <= 1'b1;
      if (parallel_fault_evt)
        hist_q[PNSC_TST_PDF] <= 1'b1;
      if (link_check_evt)
        hist_q[PNSC_TST_LSC] <= 1'b1;
    end
  end

  // disconnect events are not counted while detection is bypassed
  wire disc_evt_gated = disconnect_evt && !cfg_q[PNSC_CFG_FCON];

  pnsc_evcnt #(.W(CW)) u_disc_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(disc_evt_gated),
    .read_clear(rd_disc),
    .count_q(disc_cnt)
  );

  pnsc_evcnt #(.W(CW)) u_fcar_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(false_carrier_evt),
    .read_clear(rd_fcar),
    .count_q(fcar_cnt)
  );

  pnsc_evcnt #(.W(CW)) u_rxpk_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(rx_packet_evt),
    .read_clear(rd_rxpk),
    .count_q(rxpk_cnt)
  );

  // led and heartbeat drives are registered to keep the pins glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_led_q <= 1'b0;
      second_led_q <= 1'b0;
      hb_q <= 1'b0;
    end
    else
    begin
      first_led_q <= test_q[PNSC_TST_LEDP] ? link_pulse : first_led_activity;
      second_led_q <= cfg_q[PNSC_CFG_CSTEN] ? link_connected : second_led_activity;
      hb_q <= cfg_q[PNSC_CFG_HB] && speed_is_10;
    end
  end

  assign negotiation_loopback = test_q[PNSC_TST_LPBK];
  assign timer_speedup = cfg_q[PNSC_CFG_TFUN];
  assign link_disable_n = cfg_q[PNSC_CFG_LDN];
  assign heartbeat_active = hb_q;
  assign jabber_enable = cfg_q[PNSC_CFG_JAB];
  assign force_link_100_n = cfg_q[PNSC_CFG_FL100N];
  assign disconnect_bypass = cfg_q[PNSC_CFG_FCON];
  assign scrambler_bypass = cfg_q[PNSC_CFG_SCR];
  assign first_led_output = first_led_q;
  assign second_led_output = second_led_q;
endmodule // pnsc_top

// ---- verification/pnsc_link_partner.sv ----
`timescale 1ns/1ps
module pnsc_link_partner
#(
  parameter logic [15:0] ABILITY = 16'h05E1
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [6:0] fire, // event request per cycle
  output logic [6:0] evt_q, // event pulses toward the block
  output logic link_pulse, // partner link pulse train
  output logic [15:0] partner_ability // partner ability word
);
  logic [1:0] div_q;
  // events land one cycle after the request, like a real line decoder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_q <= 7'h00;
      div_q <= 2'h0;
    end
    else
    begin
      evt_q <= fire;
      div_q <= div_q + 2'h1;
    end
  end
  assign link_pulse = div_q[1];
  assign partner_ability = ABILITY;
endmodule // pnsc_link_partner

// ---- verification/pnsc_assertions.sv ----
`timescale 1ns/1ps
module pnsc_assertions
  import pnsc_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [pnsc_pkg::PNSC_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic link_connected, // connected link
  input wire logic speed_is_10, // 10 Mb/s mode
  input wire logic heartbeat_active, // heartbeat applied
  input wire logic negotiation_loopback, // loopback
  input wire logic jabber_enable, // jabber on
  input wire logic link_disable_n, // link disable
  input wire logic force_link_100_n // force link
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_r_lat;
    ar_take |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_exp_zero;
    ar_take && s_axi_araddr == PNSC_ADR_EXP |=> s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_exp_zero: assert property (p_exp_zero)
    else $error("expansion upper bits set");
  property p_cfg_rd;
    ar_take && s_axi_araddr == PNSC_ADR_CFG |=> s_axi_rdata[3] == $past(link_connected)
      && s_axi_rdata[31:10] == 22'h0 && s_axi_rdata[4] == 1'b0 && s_axi_rdata[1] == 1'b0;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config read wrong");
  property p_tst_rd;
    ar_take && s_axi_araddr == PNSC_ADR_TEST |=> s_axi_rdata[31:8] == 24'h0
      && s_axi_rdata[6:4] == 3'h0;
  endproperty
  a_tst_rd: assert property (p_tst_rd)
    else $error("test reserved bits set");
  property p_ctl_chg;
    $changed({negotiation_loopback, jabber_enable}) |-> $rose(s_axi_bvalid);
  endproperty
  a_ctl_chg: assert property (p_ctl_chg)
    else $error("control moved without a write");
  property p_hb;
    heartbeat_active |-> $past(speed_is_10);
  endproperty
  a_hb: assert property (p_hb)
    else $error("heartbeat outside 10 Mb/s");
  property p_rst;
    $rose(aresetn) |-> link_disable_n && jabber_enable && force_link_100_n
      && !negotiation_loopback && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
  c_exp: cover property (ar_take && s_axi_araddr == PNSC_ADR_EXP);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_hb: cover property ($rose(heartbeat_active));
endmodule // pnsc_assertions
bind pnsc_top pnsc_assertions u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .link_connected, .speed_is_10, .heartbeat_active, .negotiation_loopback,
  .jabber_enable, .link_disable_n, .force_link_100_n);

// ---- verification/pnsc_top_bench.sv ----
`timescale 1ns/1ps
module pnsc_top_bench;
  import pnsc_pkg::*;
  typedef struct packed {
    logic [11:0] adr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [1:0] resp;
    logic [7:0] ctl;
  } pnsc_row_s;
  localparam logic [15:0] PA = 16'h05E1;
  logic aclk, aresetn, lp_q;
  logic [PNSC_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] partner_ability;
  logic page_received_evt, disconnect_evt, false_carrier_evt, rx_packet_evt;
  logic ability_detect_evt, parallel_fault_evt, link_check_evt;
  logic multiple_fault_flag, partner_next_page_capable, local_next_page_capable;
  logic partner_autoneg_capable, link_connected, link_pulse, speed_is_10;
  logic first_led_activity, second_led_activity, negotiation_loopback;
  logic timer_speedup, link_disable_n;
  logic heartbeat_active, jabber_enable, force_link_100_n, disconnect_bypass;
  logic scrambler_bypass, first_led_output, second_led_output;
  logic [6:0] fire;
  wire logic [6:0] evt;
  int num_errors, check_count, cyc;
  logic [11:0] cadr [3] = '{PNSC_ADR_DISC, PNSC_ADR_FCAR, PNSC_ADR_RXPK};
  // ctl: loopback, speedup, link_disable_n, heartbeat, jabber, force_n, bypass, scrambler
  pnsc_row_s rows [9] = '{
    '{PNSC_ADR_TEST, 32'h0000FFFF, 32'h00000088, PNSC_RESP_OKAY, 8'hBC},
    '{PNSC_ADR_CFG, 32'h0000FFFF, 32'h000003E5, PNSC_RESP_OKAY, 8'hFF},
    '{PNSC_ADR_CFG, 32'h00000000, 32'h00000000, PNSC_RESP_OKAY, 8'h80},
    '{PNSC_ADR_EXP, 32'h0000FFFF, 32'h00000000, PNSC_RESP_OKAY, 8'h80},
    '{12'h1D4, 32'h00001234, 32'h00000000, PNSC_RESP_SLVERR, 8'h80},
    '{PNSC_ADR_PARTNER, 32'h0000FFFF, {16'h0000, PA}, PNSC_RESP_OKAY, 8'h80},
    '{PNSC_ADR_CFG, 32'hFFFF0020, 32'h00000020, PNSC_RESP_OKAY, 8'h82},
    '{PNSC_ADR_CFG, 32'h000003C0, 32'h000003C0, PNSC_RESP_OKAY, 8'hBC},
    '{PNSC_ADR_TEST, 32'h00000000, 32'h00000000, PNSC_RESP_OKAY, 8'h3C}
  };
  pnsc_top dut (.*);
  pnsc_link_partner #(.ABILITY(PA)) u_far (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .evt_q(evt), .link_pulse(link_pulse), .partner_ability(partner_ability));
  assign {link_check_evt, parallel_fault_evt, ability_detect_evt, rx_packet_evt,
    false_carrier_evt, disconnect_evt, page_received_evt} = evt;
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    lp_q <= link_pulse;
    cyc++;
    if (cyc == 90000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // callers enter just after a rising edge; each handshake returns just after its edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a, d, r);
    check(d, exp);
  endtask
  task automatic pulse(input logic [6:0] m, input int n);
    fire <= m;
    repeat (n) @(posedge aclk);
    fire <= 7'h00;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {multiple_fault_flag, partner_next_page_capable, local_next_page_capable} = '0;
    {partner_autoneg_capable, link_connected, first_led_activity, second_led_activity} = '0;
    s_axi_wstrb = 4'hF;
    speed_is_10 = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      axi_wr(rows[i].adr, rows[i].wd, r);
      check(32'(r), 32'(rows[i].resp));
      axi_rd(rows[i].adr, d, r);
      check(d, rows[i].rd);
      check(32'(r), 32'(rows[i].resp));
      check(32'({negotiation_loopback, timer_speedup, link_disable_n, heartbeat_active,
        jabber_enable, force_link_100_n, disconnect_bypass, scrambler_bypass}), 32'(rows[i].ctl));
    end
    for (int k = 0; k < 3; k++)
    begin
      pulse(7'h02 << k, k + 3);
      rdchk(cadr[k], 32'(k + 3));
      rdchk(cadr[k], 32'h00000000);
    end
    pulse(7'h02, 1);
    fire <= 7'h02;
    @(posedge aclk);
    fire <= 7'h00;
    rdchk(PNSC_ADR_DISC, 32'h00000001);
    rdchk(PNSC_ADR_DISC, 32'h00000001);
    pulse(7'h02, 65537);
    rdchk(PNSC_ADR_DISC, 32'h00000001);
    // disconnect events must not count while detection is bypassed
    wr(PNSC_ADR_CFG, 32'h000003E0);
    pulse(7'h02, 2);
    rdchk(PNSC_ADR_DISC, 32'h00000000);
    wr(PNSC_ADR_CFG, 32'h000003C0);
    {multiple_fault_flag, partner_next_page_capable} <= 2'b10;
    {local_next_page_capable, partner_autoneg_capable} <= 2'b11;
    pulse(7'h01, 1);
    rdchk(PNSC_ADR_EXP, 32'h00000017);
    rdchk(PNSC_ADR_PARTNER, {16'h0000, PA});
    rdchk(PNSC_ADR_EXP, 32'h00000015);
    {multiple_fault_flag, partner_next_page_capable} <= 2'b01;
    {local_next_page_capable, partner_autoneg_capable} <= 2'b00;
    link_connected <= 1'b1;
    rdchk(PNSC_ADR_EXP, 32'h00000008);
    wr(PNSC_ADR_TEST, 32'h00000008);
    wr(PNSC_ADR_CFG, 32'h000003C4);
    rdchk(PNSC_ADR_CFG, 32'h000003CC);
    repeat (8)
    begin
      @(negedge aclk);
      check(32'(first_led_output), 32'(lp_q));
      check(32'(second_led_output), 32'h00000001);
    end
    @(posedge aclk);
    wr(PNSC_ADR_TEST, 32'h00000000);
    wr(PNSC_ADR_CFG, 32'h000003C0);
    first_led_activity <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'({first_led_output, second_led_output}), 32'h00000002);
    pulse(7'h08, 2);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(PNSC_ADR_TEST, 32'h00000000);
    rdchk(PNSC_ADR_CFG, 32'h000003C8);
    rdchk(PNSC_ADR_RXPK, 32'h00000000);
    rdchk(PNSC_ADR_EXP, 32'h00000008);
    pulse(7'h70, 1);
    rdchk(PNSC_ADR_TEST, 32'h00000007);
    speed_is_10 <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'(heartbeat_active), 32'h00000000);
    complete_run();
  end
endmodule // pnsc_top_bench
